// ==== dv/ptp_trigger_timestamp_control_tb_top.sv ====
// Self-checking bench for the event trigger and timestamp control block
`timescale 1ns/1ps
module ptp_trigger_timestamp_control_tb_top import ptc_pkg::*; ;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [SEC_W-1:0] sys_time_sec = 32'h00000004;
   logic [NS_W-1:0] sys_time_ns = 30'h00000064;
   logic pin_in = 1'b0;
   logic pin_out;
   logic pin_oe;
   logic stamp_irq;
   int err_count = 0;
   int tests_run = 0;
   int lat0;
   int lat1;

   // Device under test
   ptc_top u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_time_sec(sys_time_sec),
      .sys_time_ns(sys_time_ns), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .stamp_irq(stamp_irq));

   // 50 MHz clock
   always #10 clk = ~clk;

   // Compare seen against expected
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One Avalon-MM transfer, held until waitrequest is seen low
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      // Sample waitrequest at each rising edge, read data once it is seen low
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge clk);
         k++;
      end
      q = avs_readdata;
      if (k >= 50) begin
         err_count++;
         $display("MISMATCH bus answer expected done seen stuck");
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : xfer

   // Register write
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   // Register read, masked compare
   task rdc(input string what, input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      chk(what, q & mask, exp);
   endtask : rdc

   // Cycles until the pin drive goes high
   task wait_pin(output int lat);
      lat = 0;
      while (pin_out !== 1'b1 && lat < 20) begin
         @(negedge clk);
         lat++;
      end
   endtask : wait_pin

   // One rising edge on the pin
   task pulse();
      @(posedge clk);
      pin_in <= 1'b1;
      repeat (5) @(posedge clk);
      pin_in <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : pulse

   // Counts and verdict
   task give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("MISMATCH watchdog expected finish seen timeout");
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("pin_oe reset", {31'h0, pin_oe}, 32'h00000000);
      rdc("ctrl reset", OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
      rdc("unmapped", 12'h600, 32'hFFFFFFFF, 32'h00000000);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_INDEX, i);
         wr(OFS_TNS, 32'hFFFFFFF0 | i);
         wr(OFS_TSEC, 32'hA5A50000 + i);
      end
      for (int i = 0; i < 3; i++) begin
         wr(OFS_INDEX, i);
         rdc("target ns", OFS_TNS, 32'hFFFFFFFF, 32'h3FFFFFF0 | i);
         rdc("target sec", OFS_TSEC, 32'hFFFFFFFF, 32'hA5A50000 + i);
      end
      wr(OFS_INDEX, 32'h00000003);
      rdc("no unit ns", OFS_TNS, 32'hFFFFFFFF, 32'h00000000);
      pin_in <= 1'b1;
      repeat (4) @(posedge clk);
      rdc("monitor high", OFS_CTRL, 32'h00000080, 32'h00000080);
      pin_in <= 1'b0;
      repeat (4) @(posedge clk);
      rdc("monitor low", OFS_CTRL, 32'h00000080, 32'h00000000);
      // Fire on reaching target, registered then combinational source
      wr(OFS_INDEX, 32'h00000000);
      wr(OFS_TNS, 32'h00000064);
      wr(OFS_TSEC, 32'h00000005);
      wr(OFS_CTRL, 32'h00000048);
      @(negedge clk);
      chk("pin_oe out", {31'h0, pin_oe}, 32'h00000001);
      rdc("armed", OFS_CTRL, 32'h00000018, 32'h00000018);
      chk("no early fire", {31'h0, pin_out}, 32'h00000000);
      @(posedge clk);
      sys_time_sec <= 32'h00000005;
      wait_pin(lat0);
      chk("fired reg", {31'h0, pin_out}, 32'h00000001);
      rdc("self clear", OFS_CTRL, 32'h00000018, 32'h00000000);
      sys_time_sec <= 32'h00000004;
      wr(OFS_CTRL, 32'h00000148);
      @(posedge clk);
      sys_time_sec <= 32'h00000005;
      wait_pin(lat1);
      chk("source latency", lat0 - lat1, 32'h00000001);
      // Late target: error with notify, then trigger-now
      @(posedge clk);
      sys_time_sec <= 32'h00000006;
      wr(OFS_OPT, 32'h00000002);
      wr(OFS_CTRL, 32'h00000048);
      rdc("late error", OFS_STAT, 32'h00070000, 32'h00010000);
      rdc("late inactive", OFS_CTRL, 32'h00000018, 32'h00000008);
      wr(OFS_CTRL, 32'h00000040);
      rdc("error cleared", OFS_STAT, 32'h00070000, 32'h00000000);
      wr(OFS_OPT, 32'h00000003);
      wr(OFS_CTRL, 32'h00000048);
      rdc("fire now", OFS_CTRL, 32'h00000018, 32'h00000000);
      rdc("fire now no error", OFS_STAT, 32'h00070000, 32'h00000000);
      // Trigger soft clear on unit 1
      sys_time_sec <= 32'h00000004;
      wr(OFS_INDEX, 32'h00000001);
      wr(OFS_CTRL, 32'h00000048);
      wr(OFS_CTRL, 32'h0000004C);
      rdc("soft clear idle", OFS_CTRL, 32'h00000018, 32'h00000000);
      rdc("soft clear target", OFS_TNS, 32'hFFFFFFFF, 32'h00000000);
      wr(OFS_CTRL, 32'h00000000);
      // Timestamp unit 0 arm, count, interrupt
      wr(OFS_INDEX, 32'h00000000);
      chk("pin_oe in", {31'h0, pin_oe}, 32'h00000000);
      wr(OFS_CTRL, 32'h00000022);
      pulse();
      rdc("stamp ready", OFS_STAT, 32'h0000FF01, 32'h00000101);
      chk("irq on", {31'h0, stamp_irq}, 32'h00000001);
      wr(OFS_INDEX, 32'h00000100);
      rdc("unit1 idle", OFS_CTRL, 32'h00000022, 32'h00000000);
      wr(OFS_INDEX, 32'h00000000);
      wr(OFS_CTRL, 32'h00000020);
      rdc("disarm clears", OFS_STAT, 32'h00000011, 32'h00000000);
      wr(OFS_CTRL, 32'h00000022);
      rdc("arm zeroes count", OFS_STAT, 32'h0000FF00, 32'h00000000);
      chk("irq off", {31'h0, stamp_irq}, 32'h00000000);
      wr(OFS_CTRL, 32'h00000002);
      pulse();
      rdc("ready masked", OFS_STAT, 32'h00000001, 32'h00000001);
      chk("irq masked", {31'h0, stamp_irq}, 32'h00000000);
      wr(OFS_CTRL, 32'h00000023);
      rdc("stamp soft clear", OFS_CTRL, 32'h00000023, 32'h00000001);
      rdc("stamp defaults", OFS_STAT, 32'h0000FF11, 32'h00000000);
      give_verdict();
   end
endmodule : ptp_trigger_timestamp_control_tb_top

// ==== src/ptc_pkg.sv ====
// Shared constants for the event trigger and timestamp control block
package ptc_pkg;
   // Register byte addresses
   localparam logic [11:0] OFS_CTRL = 12'h52C;
   localparam logic [11:0] OFS_TNS = 12'h530;
   localparam logic [11:0] OFS_TSEC = 12'h534;
   localparam logic [11:0] OFS_INDEX = 12'h540;
   localparam logic [11:0] OFS_STAT = 12'h544;
   localparam logic [11:0] OFS_OPT = 12'h548;
   // Control and status field positions
   localparam int B_OUT_SEL = 8;
   localparam int B_IN_MON = 7;
   localparam int B_DIR = 6;
   localparam int B_IRQ_EN = 5;
   localparam int B_ACTIVE = 4;
   localparam int B_FIRE_EN = 3;
   localparam int B_FIRE_CLR = 2;
   localparam int B_ARM = 1;
   localparam int B_STAMP_CLR = 0;
   // Index register fields
   localparam int B_SIDX = 8;
   localparam int FIDX_W = 2;
   // Option register fields
   localparam int B_NOW = 0;
   localparam int B_NOTIFY = 1;
   // Status register fields
   localparam int B_RDY_LSB = 0;
   localparam int B_OVF = 4;
   localparam int B_CNT_LSB = 8;
   localparam int B_ERR_LSB = 16;
   // Widths and reset values
   localparam int NS_W = 30;
   localparam int SEC_W = 32;
   localparam logic [31:0] ZERO32 = 32'h00000000;
endpackage : ptc_pkg

// ==== src/ptc_top.sv ====
// Event trigger output and timestamp input control with Avalon-MM registers
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ptc_top import ptc_pkg::*; #(
   parameter int N_FIRE = 3, // Trigger output units
   parameter int N_STAMP = 2, // Timestamp input units
   parameter int CNT_W = 8 // Event counter width
) (
   input wire logic clk, // 50 MHz system clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic [11:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic [SEC_W-1:0] sys_time_sec, // System time seconds
   input wire logic [NS_W-1:0] sys_time_ns, // System time nanoseconds
   input wire logic pin_in, // Pin level, asynchronous
   output logic pin_out, // Pin drive value
   output logic pin_oe, // Pin output enable
   output logic stamp_irq // Stamp interrupt request
);
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic out_sel;
      logic dir;
      logic [FIDX_W-1:0] fidx;
      logic sidx;
      logic [N_FIRE-1:0] fen;
      logic [N_FIRE-1:0] ferr;
      logic [N_FIRE-1:0] fclr;
      logic [N_FIRE-1:0] fnow;
      logic [N_FIRE-1:0] fnotify;
      logic [N_FIRE-1:0][NS_W-1:0] tns;
      logic [N_FIRE-1:0][SEC_W-1:0] tsec;
      logic [N_STAMP-1:0] sarm;
      logic [N_STAMP-1:0] sirq;
      logic [N_STAMP-1:0] sclr;
      logic [N_STAMP-1:0] srdy;
      logic [N_STAMP-1:0] sovf;
      logic [N_STAMP-1:0][CNT_W-1:0] scnt;
      logic [1:0] pin_sync;
      logic pin_prev;
      logic fire_dly;
      logic pin_out;
      logic pin_oe;
      logic irq;
   } ptc_state_t;

   ptc_state_t st_ff;
   ptc_state_t nxt_st;
   logic [N_FIRE-1:0] fire;
   logic [N_FIRE-1:0] late;
   logic [N_FIRE-1:0] active;
   logic [31:0] wmask;
   logic fidx_ok;
   logic req;
   logic take;
   logic pin_edge;

   // Unit status and time compare
   always_comb begin
      for (int i = 0; i < N_FIRE; i++) begin
         late[i] = {sys_time_sec, sys_time_ns} > {st_ff.tsec[i], st_ff.tns[i]};
         active[i] = st_ff.fen[i] & ~st_ff.ferr[i] & ~st_ff.fclr[i];
         fire[i] = active[i] & ({sys_time_sec, sys_time_ns} >= {st_ff.tsec[i], st_ff.tns[i]});
      end
   end

   // Bus decode helpers
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign fidx_ok = 32'(st_ff.fidx) < N_FIRE;
   assign req = avs_read | avs_write;
   assign take = req & st_ff.waitreq;
   assign pin_edge = st_ff.pin_sync[1] & ~st_ff.pin_prev & ~st_ff.dir;

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pin_sync = {st_ff.pin_sync[0], pin_in};
      nxt_st.pin_prev = st_ff.pin_sync[1];
      // Hardware self-clear of fired units
      for (int i = 0; i < N_FIRE; i++) begin
         if (fire[i]) begin
            nxt_st.fen[i] = 1'b0;
         end
      end
      // Bus handshake: one wait cycle then answer
      nxt_st.waitreq = 1'b1;
      nxt_st.rdata = ZERO32;
      if (take) begin
         nxt_st.waitreq = 1'b0;
         if (avs_read) begin
            if (avs_address == OFS_CTRL) begin
               nxt_st.rdata[B_OUT_SEL] = st_ff.out_sel;
               nxt_st.rdata[B_IN_MON] = st_ff.pin_sync[1];
               nxt_st.rdata[B_DIR] = st_ff.dir;
               nxt_st.rdata[B_IRQ_EN] = st_ff.sirq[st_ff.sidx];
               nxt_st.rdata[B_ARM] = st_ff.sarm[st_ff.sidx];
               nxt_st.rdata[B_STAMP_CLR] = st_ff.sclr[st_ff.sidx];
               if (fidx_ok) begin
                  nxt_st.rdata[B_ACTIVE] = active[st_ff.fidx];
                  nxt_st.rdata[B_FIRE_EN] = st_ff.fen[st_ff.fidx];
                  nxt_st.rdata[B_FIRE_CLR] = st_ff.fclr[st_ff.fidx];
               end
            end else if (avs_address == OFS_TNS) begin
               if (fidx_ok) begin
                  nxt_st.rdata[NS_W-1:0] = st_ff.tns[st_ff.fidx];
               end
            end else if (avs_address == OFS_TSEC) begin
               if (fidx_ok) begin
                  nxt_st.rdata = st_ff.tsec[st_ff.fidx];
               end
            end else if (avs_address == OFS_INDEX) begin
               nxt_st.rdata[FIDX_W-1:0] = st_ff.fidx;
               nxt_st.rdata[B_SIDX] = st_ff.sidx;
            end else if (avs_address == OFS_STAT) begin
               nxt_st.rdata[B_RDY_LSB +: N_STAMP] = st_ff.srdy;
               nxt_st.rdata[B_OVF] = st_ff.sovf[st_ff.sidx];
               nxt_st.rdata[B_CNT_LSB +: CNT_W] = st_ff.scnt[st_ff.sidx];
               nxt_st.rdata[B_ERR_LSB +: N_FIRE] = st_ff.ferr;
            end else if (avs_address == OFS_OPT) begin
               if (fidx_ok) begin
                  nxt_st.rdata[B_NOW] = st_ff.fnow[st_ff.fidx];
                  nxt_st.rdata[B_NOTIFY] = st_ff.fnotify[st_ff.fidx];
               end
            end
         end else begin
            if (avs_address == OFS_CTRL) begin
               if (avs_byteenable[1]) begin
                  nxt_st.out_sel = avs_writedata[B_OUT_SEL];
               end
               if (avs_byteenable[0]) begin
                  nxt_st.dir = avs_writedata[B_DIR];
                  nxt_st.sirq[st_ff.sidx] = avs_writedata[B_IRQ_EN];
                  nxt_st.sclr[st_ff.sidx] = avs_writedata[B_STAMP_CLR];
                  nxt_st.sarm[st_ff.sidx] = avs_writedata[B_ARM];
                  if (avs_writedata[B_ARM]) begin
                     nxt_st.scnt[st_ff.sidx] = '0;
                  end else begin
                     nxt_st.srdy[st_ff.sidx] = 1'b0;
                     nxt_st.sovf[st_ff.sidx] = 1'b0;
                  end
                  if (fidx_ok) begin
                     nxt_st.fclr[st_ff.fidx] = avs_writedata[B_FIRE_CLR];
                     nxt_st.fen[st_ff.fidx] = avs_writedata[B_FIRE_EN];
                     if (!avs_writedata[B_FIRE_EN]) begin
                        nxt_st.ferr[st_ff.fidx] = 1'b0;
                     end else if (late[st_ff.fidx] && !st_ff.fnow[st_ff.fidx]) begin
                        // Late target without trigger-now never fires
                        nxt_st.ferr[st_ff.fidx] = st_ff.fnotify[st_ff.fidx];
                        nxt_st.fen[st_ff.fidx] = st_ff.fnotify[st_ff.fidx];
                     end
                  end
               end
            end else if (avs_address == OFS_TNS) begin
               if (fidx_ok) begin
                  nxt_st.tns[st_ff.fidx] = NS_W'((avs_writedata & wmask) |
                     ({2'b00, st_ff.tns[st_ff.fidx]} & ~wmask));
               end
            end else if (avs_address == OFS_TSEC) begin
               if (fidx_ok) begin
                  nxt_st.tsec[st_ff.fidx] = (avs_writedata & wmask) |
                     (st_ff.tsec[st_ff.fidx] & ~wmask);
               end
            end else if (avs_address == OFS_INDEX) begin
               if (avs_byteenable[0]) begin
                  nxt_st.fidx = avs_writedata[FIDX_W-1:0];
               end
               if (avs_byteenable[1]) begin
                  nxt_st.sidx = avs_writedata[B_SIDX];
               end
            end else if (avs_address == OFS_OPT) begin
               if (fidx_ok && avs_byteenable[0]) begin
                  nxt_st.fnow[st_ff.fidx] = avs_writedata[B_NOW];
                  nxt_st.fnotify[st_ff.fidx] = avs_writedata[B_NOTIFY];
               end
            end
         end
      end
      // Stamp event capture, software clear wins over set
      for (int j = 0; j < N_STAMP; j++) begin
         if (st_ff.sarm[j] && !st_ff.sclr[j] && pin_edge) begin
            nxt_st.scnt[j] = st_ff.scnt[j] + CNT_W'(1);
            nxt_st.srdy[j] = 1'b1;
            if (&st_ff.scnt[j]) begin
               nxt_st.sovf[j] = 1'b1;
            end
         end
         if (st_ff.sclr[j]) begin
            nxt_st.sarm[j] = 1'b0;
            nxt_st.sirq[j] = 1'b0;
            nxt_st.srdy[j] = 1'b0;
            nxt_st.sovf[j] = 1'b0;
            nxt_st.scnt[j] = '0;
         end
      end
      // Trigger soft clear holds unit at defaults
      for (int i = 0; i < N_FIRE; i++) begin
         if (st_ff.fclr[i]) begin
            nxt_st.fen[i] = 1'b0;
            nxt_st.ferr[i] = 1'b0;
            nxt_st.fnow[i] = 1'b0;
            nxt_st.fnotify[i] = 1'b0;
            nxt_st.tns[i] = '0;
            nxt_st.tsec[i] = '0;
         end
      end
      // Pin drive and interrupt
      nxt_st.fire_dly = |fire;
      nxt_st.pin_out = (st_ff.out_sel ? |fire : st_ff.fire_dly) & st_ff.dir;
      nxt_st.pin_oe = st_ff.dir;
      nxt_st.irq = |(st_ff.srdy & st_ff.sirq);
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.waitreq <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitreq;
   assign pin_out = st_ff.pin_out;
   assign pin_oe = st_ff.pin_oe;
   assign stamp_irq = st_ff.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_wr_ctrl;
      avs_write && st_ff.waitreq && avs_address == OFS_CTRL && avs_byteenable[0];
   endsequence

   property p_fire_self_clear;
      fire[0] && !(avs_write && st_ff.waitreq) |=> !st_ff.fen[0];
   endproperty
   a_fire_self_clear: assert property (p_fire_self_clear) else $error("fired unit stays enabled");

   property p_arm_zero_count;
      s_wr_ctrl ##0 avs_writedata[B_ARM] && !pin_edge |=> st_ff.scnt[$past(st_ff.sidx)] == '0;
   endproperty
   a_arm_zero_count: assert property (p_arm_zero_count) else $error("arm left counter");

   property p_disarm_clears;
      s_wr_ctrl ##0 !avs_writedata[B_ARM] && !pin_edge |=> !st_ff.srdy[$past(st_ff.sidx)];
   endproperty
   a_disarm_clears: assert property (p_disarm_clears) else $error("ready survives disarm");

   property p_stamp_clear;
      st_ff.sclr[0] |=> !st_ff.sarm[0] && st_ff.scnt[0] == '0;
   endproperty
   a_stamp_clear: assert property (p_stamp_clear) else $error("stamp clear ignored");

   property p_fire_clear;
      st_ff.fclr[1] |=> !st_ff.fen[1] && st_ff.tsec[1] == '0 && !active[1];
   endproperty
   a_fire_clear: assert property (p_fire_clear) else $error("trigger clear ignored");

   property p_comb_path;
      st_ff.out_sel && st_ff.dir && $stable(st_ff.out_sel) |=> pin_out == $past(|fire);
   endproperty
   a_comb_path: assert property (p_comb_path) else $error("combinational source wrong");

   property p_reg_path;
      !st_ff.out_sel && st_ff.dir ##1 !st_ff.out_sel && st_ff.dir |=> pin_out == $past(|fire, 2);
   endproperty
   a_reg_path: assert property (p_reg_path) else $error("registered source wrong");

   property p_monitor;
      take && avs_read && avs_address == OFS_CTRL |=> avs_readdata[B_IN_MON] == $past(st_ff.pin_sync[1]);
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor bit wrong");

   property p_ns_reserved;
      take && avs_read && avs_address == OFS_TNS |=> avs_readdata[31:NS_W] == 2'b00 && !avs_waitrequest;
   endproperty
   a_ns_reserved: assert property (p_ns_reserved) else $error("reserved ns bits set");

   property p_irq_gate;
      !(|(st_ff.srdy & st_ff.sirq)) |=> !stamp_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("masked interrupt raised");

   property p_err_clear;
      s_wr_ctrl ##0 fidx_ok && !avs_writedata[B_FIRE_EN] |=> !st_ff.ferr[$past(st_ff.fidx)];
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error not cleared");

   property p_oe_dir;
      ##1 pin_oe == $past(st_ff.dir);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("output enable mismatch");
endmodule : ptc_top
